// File: tb/swpc_line_model.sv
`timescale 1ns/1ps
`default_nettype none

module swpc_line_model
(
    input wire logic ref_clk,
    input wire logic go,
    input wire logic [1:0] kind,
    input wire logic [3:0] dly,
    output logic line_released,
    output logic edge_is_short_recovery,
    output logic edge_after_reset_or_presence,
    output logic slot_end,
    output logic line_above_threshold
);
    logic [5:0] cnt_reg = 6'h3F;
    logic [1:0] kind_reg = 2'h0;
    logic [3:0] dly_reg = 4'h0;

    always_ff @(posedge ref_clk)
    begin
        if (go)
        begin
            cnt_reg <= 6'h00;
            kind_reg <= kind;
            dly_reg <= dly;
        end
        else if (cnt_reg != 6'h3F)
        begin
            cnt_reg <= cnt_reg + 6'h01;
        end
    end

    // Pulldown ends at count 2; qualifiers toggle outside that pulse
    assign line_released = (cnt_reg == 6'h02);
    assign edge_is_short_recovery = line_released ? (kind_reg == 2'h1) : cnt_reg[0];
    assign edge_after_reset_or_presence = line_released ? (kind_reg == 2'h2) : ~cnt_reg[0];
    // Slow or prompt rise set by dly
    assign line_above_threshold = (cnt_reg > 6'h02 + {2'h0, dly_reg});
    // Slot long enough to cover the recovery span
    assign slot_end = (cnt_reg == 6'h28) && (kind_reg != 2'h2);
endmodule

`default_nettype wire

// File: tb/swpc_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module swpc_port_monitor
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic sleep_pin_n,
    input wire logic master_reset_cmd,
    input wire logic line_cmd_start,
    input wire logic cfg_wr_ack,
    input wire logic [7:0] cfg_wr_addr,
    input wire logic [7:0] cfg_wr_data,
    input wire logic [7:0] cfg_rd_addr,
    input wire logic [7:0] cfg_rd_data,
    input wire logic cfg_rd_hit,
    input wire logic port_power_down,
    input wire logic active_pullup_enable,
    input wire logic strong_pullup_enable,
    input wire logic line_busy_flag,
    input wire logic line_released,
    input wire logic edge_is_short_recovery,
    input wire logic slot_end,
    input wire logic line_above_threshold,
    input wire swpc_pkg::swpc_timing_t timing,
    input wire swpc_pkg::swpc_line_mode_t line_mode,
    input wire swpc_pkg::swpc_pad_ctl_t pad_ctl
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    sleep_line_a: assert property (!sleep_pin_n [*6] |-> line_mode == swpc_pkg::SWPC_LINE_SLEEP
        && pad_ctl.drive_low && !pad_ctl.weak_pullup_connect && !port_power_down && timing == '0)
        else $error("sleep state wrong");
    port_down_a: assert property ((sleep_pin_n && port_power_down) [*3] |->
        line_mode == swpc_pkg::SWPC_LINE_PORT_DOWN && pad_ctl.drive_low && !pad_ctl.weak_pullup_connect)
        else $error("power-down state wrong");
    passive_only_a: assert property ((!active_pullup_enable && !strong_pullup_enable) [*8]
        |-> !pad_ctl.apu_transistor_on) else $error("transistor on in resistor mode");
    short_edge_a: assert property (line_released && edge_is_short_recovery && !strong_pullup_enable
        |=> !pad_ctl.apu_transistor_on [*8]) else $error("pull-up on short recovery");
    thresh_first_a: assert property ($rose(pad_ctl.apu_transistor_on) && !strong_pullup_enable
        |-> $past(line_above_threshold, 2)) else $error("transistor before threshold");
    apu_on_a: assert property (line_released && active_pullup_enable && !edge_is_short_recovery
        && !pad_ctl.drive_low |-> ##[1:16] pad_ctl.apu_transistor_on) else $error("no active pull-up");
    slot_off_a: assert property (pad_ctl.apu_transistor_on && slot_end && !strong_pullup_enable
        |-> ##[1:2] !pad_ctl.apu_transistor_on) else $error("pull-up past slot end");
    spu_end_a: assert property (strong_pullup_enable && (line_cmd_start || master_reset_cmd)
        |=> !strong_pullup_enable) else $error("strong pull-up not ended");
    cfg_now_a: assert property (cfg_wr_ack && !line_busy_flag && cfg_wr_addr == 8'h68 |=>
        {timing.reset_low_time_od, timing.reset_low_time_std} == $past(cfg_wr_data))
        else $error("code not applied");
    cfg_wait_a: assert property (cfg_wr_ack && line_busy_flag && $past(line_busy_flag)
        |=> $stable(timing)) else $error("code applied while busy");
    rd_map_a: assert property (cfg_rd_hit == (cfg_rd_addr >= 8'h68 && cfg_rd_addr <= 8'h6D)
        && (cfg_rd_hit || cfg_rd_data == 8'h00)) else $error("address map wrong");
endmodule

bind swpc_port swpc_port_monitor mon (.*);

`default_nettype wire

// File: tb/swpc_port_tb.sv
`timescale 1ns/1ps
`default_nettype none

module swpc_port_tb;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic sleep_pin_n = 1'b1;
    logic master_reset_cmd = 1'b0;
    logic line_cmd_start = 1'b0;
    logic cfg_wr_ack = 1'b0;
    logic [7:0] cfg_wr_addr = 8'h00;
    logic [7:0] cfg_wr_data = 8'h00;
    logic [7:0] cfg_rd_addr = 8'h00;
    logic [7:0] cfg_rd_data;
    logic cfg_rd_hit;
    logic ctl_wr = 1'b0;
    logic [2:0] ctl = 3'h0;
    logic port_power_down;
    logic active_pullup_enable;
    logic strong_pullup_enable;
    logic line_busy_flag = 1'b0;
    logic overdrive = 1'b0;
    logic line_released;
    logic edge_is_short_recovery;
    logic edge_after_reset_or_presence;
    logic slot_end;
    logic line_above_threshold;
    logic go = 1'b0;
    logic [1:0] kind = 2'h0;
    logic [3:0] dly = 4'h0;
    swpc_pkg::swpc_timing_t timing;
    swpc_pkg::swpc_line_mode_t line_mode;
    swpc_pkg::swpc_pad_ctl_t pad_ctl;
    logic [7:0] wd [6];
    int fail_count = 0;
    int n_tests = 0;

    // Control bits packed as power-down, active, strong
    swpc_port dut (.*, .ctl_port_power_down(ctl[2]), .ctl_active_pullup_enable(ctl[1]),
        .ctl_strong_pullup_enable(ctl[0]));
    swpc_line_model far_end (.*);

    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic test_done;
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk1(input logic g, input logic e);
        chk8({7'h00, g}, {7'h00, e});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Strobe held across a burst so it never drops and rises in one step
    task automatic wr(input logic [7:0] a, input int n);
        cfg_wr_ack <= 1'b1;
        for (int i = 0; i < n; i++)
        begin
            cfg_wr_addr <= a + 8'(i);
            cfg_wr_data <= wd[i];
            @(posedge ref_clk);
        end
        cfg_wr_ack <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
        cfg_rd_addr <= a;
        @(posedge ref_clk);
        #1;
        chk8(cfg_rd_data, e);
        chk1(cfg_rd_hit, h);
    endtask

    task automatic setc(input logic [2:0] c);
        ctl_wr <= 1'b1;
        ctl <= c;
        @(posedge ref_clk);
        ctl_wr <= 1'b0;
        tick(2);
    endtask

    task automatic mode(input swpc_pkg::swpc_line_mode_t m, input logic w, input logic d);
        chk8({6'h00, line_mode}, {6'h00, m});
        chk1(pad_ctl.weak_pullup_connect, w);
        chk1(pad_ctl.drive_low, d);
    endtask

    // One rising edge; counts transistor cycles over a fixed window
    task automatic pull(input logic [1:0] k, input logic [3:0] d, input int lo, input int hi);
        int n;
        n = 0;
        kind <= k;
        dly <= d;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (700)
        begin
            @(posedge ref_clk);
            if (pad_ctl.apu_transistor_on === 1'b1)
                n++;
        end
        chk1(n >= lo && n <= hi, 1'b1);
    endtask

    function automatic logic [7:0] tbyte(input int i);
        case (i)
            0: return {timing.reset_low_time_od, timing.reset_low_time_std};
            1: return {timing.presence_sample_time_od, timing.presence_sample_time_std};
            2: return {timing.write_zero_low_time_od, timing.write_zero_low_time_std};
            3: return {4'h0, timing.recovery_time};
            4: return {4'h0, timing.weak_pullup_resistor};
            default: return {4'h0, timing.write_one_low_time_od};
        endcase
    endfunction

    initial
    begin
        wd = '{8'hA5, 8'h3C, 8'h96, 8'hF7, 8'hE2, 8'hD1};
        tick(20);
        reset <= 1'b0;
        tick(8);
        for (int i = 0; i < 6; i++)
            rd(8'h68 + 8'(i), 8'h00, 1'b1);
        rd(8'h67, 8'h00, 1'b0);
        rd(8'h6E, 8'h00, 1'b0);
        mode(swpc_pkg::SWPC_LINE_NORMAL, 1'b1, 1'b0);
        wr(8'h68, 6);
        for (int i = 0; i < 6; i++)
        begin
            chk8(tbyte(i), (i < 3) ? wd[i] : {4'h0, wd[i][3:0]});
            rd(8'h68 + 8'(i), wd[i], 1'b1);
        end
        line_busy_flag <= 1'b1;
        wd[0] = 8'h12;
        tick(1);
        wr(8'h68, 1);
        tick(3);
        chk8(tbyte(0), 8'hA5);
        line_busy_flag <= 1'b0;
        tick(3);
        chk8(tbyte(0), 8'h12);
        setc(3'h4);
        chk1(port_power_down, 1'b1);
        mode(swpc_pkg::SWPC_LINE_PORT_DOWN, 1'b0, 1'b1);
        setc(3'h0);
        mode(swpc_pkg::SWPC_LINE_NORMAL, 1'b1, 1'b0);
        pull(2'h0, 4'h1, 0, 0);
        setc(3'h2);
        chk1(active_pullup_enable, 1'b1);
        pull(2'h0, 4'h1, 30, 37);
        pull(2'h0, 4'h8, 23, 30);
        pull(2'h1, 4'h1, 0, 0);
        pull(2'h2, 4'h1, 618, 628);
        overdrive <= 1'b1;
        pull(2'h2, 4'h8, 118, 128);
        overdrive <= 1'b0;
        setc(3'h3);
        pull(2'h0, 4'h1, 680, 700);
        line_cmd_start <= 1'b1;
        tick(1);
        line_cmd_start <= 1'b0;
        tick(3);
        chk1(strong_pullup_enable, 1'b0);
        chk1(pad_ctl.apu_transistor_on, 1'b0);
        setc(3'h3);
        setc(3'h6);
        chk1(strong_pullup_enable, 1'b0);
        master_reset_cmd <= 1'b1;
        tick(1);
        master_reset_cmd <= 1'b0;
        tick(3);
        chk8(tbyte(0), 8'h00);
        setc(3'h4);
        sleep_pin_n <= 1'b0;
        tick(8);
        mode(swpc_pkg::SWPC_LINE_SLEEP, 1'b0, 1'b1);
        sleep_pin_n <= 1'b1;
        tick(8);
        chk1(port_power_down, 1'b0);
        mode(swpc_pkg::SWPC_LINE_NORMAL, 1'b1, 1'b0);
        test_done;
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        test_done;
    end
endmodule

`default_nettype wire

// File: verilog/swpc_cfg_bytes.sv
`timescale 1ns/1ps
`default_nettype none
`include "swpc_consts.svh"

module swpc_cfg_bytes
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic soft_reset,
    input wire logic wr_ack,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic line_busy_flag,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    output logic rd_hit,
    output swpc_pkg::swpc_timing_t timing
);

    localparam logic [7:0] RST_CODE [`SWPC_NUM_CFG] = '{
        `SWPC_RST_RSTL, `SWPC_RST_MSP, `SWPC_RST_W0L,
        `SWPC_RST_REC, `SWPC_RST_PULLUP_RESISTOR_CFG, `SWPC_RST_W1L};

    logic [7:0] stored_reg [`SWPC_NUM_CFG];
    logic [7:0] active_reg [`SWPC_NUM_CFG];
    logic [`SWPC_NUM_CFG-1:0] pending_reg;

    genvar gi;
    generate
        for (gi = 0; gi < `SWPC_NUM_CFG; gi++)
        begin : g_byte
            logic hit;
            assign hit = wr_ack && (wr_addr == `SWPC_ADDR_RSTL + 8'(gi));
            // Stored byte keeps all eight bits, upper nibble included
            always_ff @(posedge ref_clk or posedge reset)
            begin
                if (reset)
                    stored_reg[gi] <= RST_CODE[gi];
                else if (soft_reset)
                    stored_reg[gi] <= RST_CODE[gi];
                else if (hit)
                    stored_reg[gi] <= wr_data;
            end
            always_ff @(posedge ref_clk or posedge reset)
            begin
                if (reset)
                    pending_reg[gi] <= 1'b0;
                else if (soft_reset)
                    pending_reg[gi] <= 1'b0;
                else if (hit && line_busy_flag)
                    pending_reg[gi] <= 1'b1;
                else if (!line_busy_flag)
                    pending_reg[gi] <= 1'b0;
            end
            always_ff @(posedge ref_clk or posedge reset)
            begin
                if (reset)
                    active_reg[gi] <= RST_CODE[gi];
                else if (soft_reset)
                    active_reg[gi] <= RST_CODE[gi];
                else if (hit && !line_busy_flag)
                    active_reg[gi] <= wr_data;
                else if (pending_reg[gi] && !line_busy_flag)
                    active_reg[gi] <= stored_reg[gi];
            end
        end
    endgenerate

    always_comb
    begin
        rd_hit = (rd_addr >= `SWPC_ADDR_RSTL) && (rd_addr <= `SWPC_ADDR_W1L);
        rd_data = 8'h00;
        for (int i = 0; i < `SWPC_NUM_CFG; i++)
        begin
            if (rd_addr == `SWPC_ADDR_RSTL + 8'(i))
                rd_data = stored_reg[i];
        end
    end

    // Upper nibbles of the last three bytes are never decoded
    always_comb
    begin
        timing.reset_low_time_std = active_reg[0][`SWPC_STD_LSB +: 4];
        timing.reset_low_time_od = active_reg[0][`SWPC_OD_LSB +: 4];
        timing.presence_sample_time_std = active_reg[1][`SWPC_STD_LSB +: 4];
        timing.presence_sample_time_od = active_reg[1][`SWPC_OD_LSB +: 4];
        timing.write_zero_low_time_std = active_reg[2][`SWPC_STD_LSB +: 4];
        timing.write_zero_low_time_od = active_reg[2][`SWPC_OD_LSB +: 4];
        timing.recovery_time = active_reg[3][`SWPC_STD_LSB +: 4];
        timing.weak_pullup_resistor = active_reg[4][`SWPC_STD_LSB +: 4];
        timing.write_one_low_time_od = active_reg[5][`SWPC_STD_LSB +: 4];
    end

endmodule
`default_nettype wire

// File: verilog/swpc_consts.svh
`ifndef SWPC_CONSTS_SVH
`define SWPC_CONSTS_SVH

// Configuration byte addresses
`define SWPC_ADDR_RSTL 8'h68
`define SWPC_ADDR_MSP 8'h69
`define SWPC_ADDR_W0L 8'h6A
`define SWPC_ADDR_REC 8'h6B
`define SWPC_ADDR_PULLUP_RESISTOR_CFG 8'h6C
`define SWPC_ADDR_W1L 8'h6D
`define SWPC_NUM_CFG 6

// Reset codes; macros so they can be changed per build
`define SWPC_RST_RSTL 8'h00
`define SWPC_RST_MSP 8'h00
`define SWPC_RST_W0L 8'h00
`define SWPC_RST_REC 8'h00
`define SWPC_RST_PULLUP_RESISTOR_CFG 8'h00
`define SWPC_RST_W1L 8'h00

// Nibble fields
`define SWPC_STD_LSB 0
`define SWPC_OD_LSB 4

// Fixed active pull-up after reset-low and presence-low, in ns
`define SWPC_FIXED_APU_STD_NS 2500
`define SWPC_FIXED_APU_OD_NS 500
`define SWPC_CLK_PERIOD_NS 4
`define SWPC_FIXED_APU_STD_CYC (`SWPC_FIXED_APU_STD_NS / `SWPC_CLK_PERIOD_NS)
`define SWPC_FIXED_APU_OD_CYC (`SWPC_FIXED_APU_OD_NS / `SWPC_CLK_PERIOD_NS)

`endif

// File: verilog/swpc_pkg.sv
`default_nettype none

package swpc_pkg;

    typedef enum logic [1:0] {
        SWPC_LINE_NORMAL,
        SWPC_LINE_PORT_DOWN,
        SWPC_LINE_SLEEP
    } swpc_line_mode_t;

    typedef struct packed {
        logic [3:0] reset_low_time_std;
        logic [3:0] reset_low_time_od;
        logic [3:0] presence_sample_time_std;
        logic [3:0] presence_sample_time_od;
        logic [3:0] write_zero_low_time_std;
        logic [3:0] write_zero_low_time_od;
        logic [3:0] recovery_time;
        logic [3:0] weak_pullup_resistor;
        logic [3:0] write_one_low_time_od;
    } swpc_timing_t;

    typedef struct packed {
        logic weak_pullup_connect;
        logic drive_low;
        logic apu_transistor_on;
    } swpc_pad_ctl_t;

endpackage

`default_nettype wire

// File: verilog/swpc_port.sv
// Functional notes
// - Sleep pin low: weak pull-up off, line held at 0V.
// - Sleep high, power-down 0: weak pull-up on, normal operation.
// - Sleep high, power-down 1: weak pull-up off, line driven to 0V.
// - Active-pullup enable chooses resistor-only or transistor-assisted rising edges.
// - No active pull-up on short-circuit recovery rising edge.
// - Fixed 2.5us/0.5us active pull-up after reset-low and presence-low edges.
// - Transistor switches on once line reaches pull-up switch threshold.
// - Transistor stays on until slot end, unless strong pull-up.
// - Slot pull-up ends at slot_end or on disable, power-down or sleep; recovery and write-one codes do not bound it.
// - Six configuration bytes at addresses 68h through 6Dh.
// - Reset-low, presence-sample, write-zero: low nibble standard, high overdrive.
// - Recovery and resistor codes both speeds; write-one code overdrive only.
// - Upper nibbles of 6Bh-6Dh writable but without effect.
// - Every device reset returns configuration bytes to defaults.
// - One write from 68h may update all six bytes in sequence.
// - New code applies at data acknowledge edge when line not busy.
// - Strong pull-up ends on line command, bit cleared, power-down, master reset.
// - Power-down defaults 0; sleep pin rising forces power-on reset.
`timescale 1ns/1ps
`default_nettype none
`include "swpc_consts.svh"

module swpc_port
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic sleep_pin_n,
    input wire logic master_reset_cmd,
    input wire logic line_cmd_start,
    input wire logic cfg_wr_ack,
    input wire logic [7:0] cfg_wr_addr,
    input wire logic [7:0] cfg_wr_data,
    input wire logic [7:0] cfg_rd_addr,
    output logic [7:0] cfg_rd_data,
    output logic cfg_rd_hit,
    input wire logic ctl_wr,
    input wire logic ctl_port_power_down,
    input wire logic ctl_active_pullup_enable,
    input wire logic ctl_strong_pullup_enable,
    output logic port_power_down,
    output logic active_pullup_enable,
    output logic strong_pullup_enable,
    input wire logic line_busy_flag,
    input wire logic overdrive,
    input wire logic line_released,
    input wire logic edge_is_short_recovery,
    input wire logic edge_after_reset_or_presence,
    input wire logic slot_end,
    input wire logic line_above_threshold,
    output swpc_pkg::swpc_timing_t timing,
    output swpc_pkg::swpc_line_mode_t line_mode,
    output swpc_pkg::swpc_pad_ctl_t pad_ctl
);

    localparam logic [9:0] FIXED_STD = 10'(`SWPC_FIXED_APU_STD_CYC);
    localparam logic [9:0] FIXED_OD = 10'(`SWPC_FIXED_APU_OD_CYC);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_THRESH,
        ST_SLOT_ON,
        ST_FIXED_ON
    } swpc_apu_state_t;

    logic slp_meta_reg;
    logic slp_sync_reg;
    logic slp_prev_reg;
    logic thr_meta_reg;
    logic thr_sync_reg;
    logic wake_pulse;
    logic soft_reset;
    logic spu_end;
    swpc_apu_state_t apu_state_reg;
    swpc_apu_state_t apu_state_next;
    logic [9:0] fixed_cnt_reg;
    logic fixed_edge_reg;
    logic apu_on_next;
    logic apu_on_reg;
    logic sleeping;
    logic apu_req;
    logic apu_abort;
    logic [9:0] fixed_load;
    logic spu_end_cmd;
    logic spu_end_bit;
    logic spu_end_pdn;
    logic weak_conn_reg;
    logic drive_low_reg;

    // Pin inputs cross into ref_clk through two flops
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            slp_meta_reg <= 1'b0;
            slp_sync_reg <= 1'b0;
        end
        else
        begin
            slp_meta_reg <= sleep_pin_n;
            slp_sync_reg <= slp_meta_reg;
        end
    end

    // Reset low like a sleeping pin, so power-up itself gives one wake reset
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            slp_prev_reg <= 1'b0;
        else
            slp_prev_reg <= slp_sync_reg;
    end

    // Threshold comparator is analog and free-running
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            thr_meta_reg <= 1'b0;
            thr_sync_reg <= 1'b0;
        end
        else
        begin
            thr_meta_reg <= line_above_threshold;
            thr_sync_reg <= thr_meta_reg;
        end
    end

    assign sleeping = !slp_sync_reg;
    assign wake_pulse = slp_sync_reg && !slp_prev_reg;
    // Sleep period and wake both reset, so a sleep-pin pulse counts as device reset
    assign soft_reset = wake_pulse || sleeping || master_reset_cmd;

    swpc_cfg_bytes u_cfg
    (
        .ref_clk(ref_clk),
        .reset(reset),
        .soft_reset(soft_reset),
        .wr_ack(cfg_wr_ack),
        .wr_addr(cfg_wr_addr),
        .wr_data(cfg_wr_data),
        .line_busy_flag(line_busy_flag),
        .rd_addr(cfg_rd_addr),
        .rd_data(cfg_rd_data),
        .rd_hit(cfg_rd_hit),
        .timing(timing)
    );

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            port_power_down <= 1'b0;
        else if (soft_reset)
            port_power_down <= 1'b0;
        else if (ctl_wr)
            port_power_down <= ctl_port_power_down;
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            active_pullup_enable <= 1'b0;
        else if (soft_reset)
            active_pullup_enable <= 1'b0;
        else if (ctl_wr)
            active_pullup_enable <= ctl_active_pullup_enable;
    end

    assign spu_end_cmd = line_cmd_start;
    assign spu_end_bit = ctl_wr && !ctl_strong_pullup_enable;
    assign spu_end_pdn = ctl_wr && ctl_port_power_down;
    // Master reset is not listed here; soft_reset covers it
    assign spu_end = spu_end_cmd || spu_end_bit || spu_end_pdn;

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            strong_pullup_enable <= 1'b0;
        else if (soft_reset || spu_end)
            strong_pullup_enable <= 1'b0;
        else if (ctl_wr)
            strong_pullup_enable <= ctl_strong_pullup_enable;
    end

    assign apu_req = line_released && active_pullup_enable && !edge_is_short_recovery;
    // Disable, power-down or sleep send the pull-up state machine to idle; after disable a strong pull-up keeps the transistor on
    assign apu_abort = !active_pullup_enable || port_power_down || sleeping;

    always_comb
    begin
        apu_state_next = apu_state_reg;
        unique case (apu_state_reg)
            ST_IDLE:
            begin
                if (apu_req)
                    apu_state_next = ST_WAIT_THRESH;
            end
            ST_WAIT_THRESH:
            begin
                if (thr_sync_reg)
                    apu_state_next = fixed_edge_reg ? ST_FIXED_ON : ST_SLOT_ON;
                else if (slot_end)
                    apu_state_next = ST_IDLE;
            end
            ST_SLOT_ON:
            begin
                if (slot_end)
                    apu_state_next = ST_IDLE;
            end
            ST_FIXED_ON:
            begin
                if (fixed_cnt_reg == 10'h001)
                    apu_state_next = ST_IDLE;
            end
        endcase
        if (apu_abort)
            apu_state_next = ST_IDLE;
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            apu_state_reg <= ST_IDLE;
        else
            apu_state_reg <= apu_state_next;
    end

    // Qualifier caught with the release, since the far side may change it later
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            fixed_edge_reg <= 1'b0;
        else if (apu_state_reg == ST_IDLE && line_released)
            fixed_edge_reg <= edge_after_reset_or_presence;
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            fixed_cnt_reg <= 10'h000;
        else if (apu_state_reg == ST_WAIT_THRESH)
            fixed_cnt_reg <= fixed_load;
        else if (fixed_cnt_reg != 10'h000)
            fixed_cnt_reg <= fixed_cnt_reg - 10'h001;
    end

    // Speed chosen at load; a speed change mid pull-up is not followed
    assign fixed_load = overdrive ? FIXED_OD : FIXED_STD;

    // Strong pull-up shares the same transistor and outlives the slot
    assign apu_on_next = (apu_state_next == ST_SLOT_ON) || (apu_state_next == ST_FIXED_ON)
        || (strong_pullup_enable && !spu_end && !soft_reset && slp_sync_reg);

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            apu_on_reg <= 1'b0;
        else
            apu_on_reg <= apu_on_next;
    end

    // Sleep outranks power-down; both drop slave power
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            line_mode <= swpc_pkg::SWPC_LINE_SLEEP;
        else if (sleeping)
            line_mode <= swpc_pkg::SWPC_LINE_SLEEP;
        else if (port_power_down)
            line_mode <= swpc_pkg::SWPC_LINE_PORT_DOWN;
        else
            line_mode <= swpc_pkg::SWPC_LINE_NORMAL;
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            weak_conn_reg <= 1'b0;
        else
            weak_conn_reg <= slp_sync_reg && !port_power_down;
    end

    // Line held low from reset until the mode is known
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            drive_low_reg <= 1'b1;
        else
            drive_low_reg <= sleeping || port_power_down;
    end

    // Transistor gated by drive_low so it never fights the pulldown
    always_comb
    begin
        pad_ctl.weak_pullup_connect = weak_conn_reg;
        pad_ctl.drive_low = drive_low_reg;
        pad_ctl.apu_transistor_on = apu_on_reg && !drive_low_reg;
    end

endmodule
`default_nettype wire
